// ==== pkg/adc_trig_params.svh ====
/*
 * named offsets, field positions, masks and reset values of the converter
 * result and trigger register block.
 * assumes: included by bare name; definitions only.
 */
`ifndef ADC_TRIG_PARAMS_SVH
`define ADC_TRIG_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_RES_LOW 8'h78
`define IDX_RES_HIGH 8'h79
`define IDX_CTRL_FIRST 8'h7A
`define IDX_CTRL_SECOND 8'h7B
`define IDX_CHAN_SEL 8'h7C
`define IDX_PIN_DIS 8'h7E
`define IDX_IRQ_STATUS 8'h80
`define IDX_IRQ_MASK 8'h81

// address layout: word index sits above the two byte-offset bits
`define IDX_LSB 2
`define IDX_MSB 9

// first control register fields
`define CF_ENABLE 7
`define CF_START 6
`define CF_AUTO 5
`define CF_DONE 4
`define CTRL_FIRST_WMASK 8'hA0

// channel select: alignment bit; bit 4 is reserved
`define CS_ALIGN 5
`define CHAN_SEL_WMASK 8'hEF

// second control register: comparator mux bit and source field
`define CB_COMP_MUX 6
`define TS_MSB 2
`define CTRL_SECOND_WMASK 8'h47

// pin buffer disable register: six live bits
`define PIN_DIS_WMASK 8'h3F

// interrupt status and mask bits
`define IRQ_DONE 0
`define IRQ_TRIG 1
`define IRQ_W 2

// widths and reset values
`define RESULT_W 10
`define REG_RESET 8'h00
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ==== pkg/adc_trig_pkg.sv ====
/*
 * types shared by the converter result and trigger register block.
 * assumes: compiled before the design module.
 */
package adc_trig_pkg;

   // auto-trigger source codes
   typedef enum logic [2:0] {
      TRIG_FREE_RUN   = 3'b000,
      TRIG_COMPARATOR = 3'b001,
      TRIG_EXT_INT0   = 3'b010,
      TRIG_T0_CMP_A   = 3'b011,
      TRIG_T0_OVF     = 3'b100,
      TRIG_T1_CMP_B   = 3'b101,
      TRIG_T1_OVF     = 3'b110,
      TRIG_T1_CAPTURE = 3'b111
   } trig_src_e;

   // one register byte
   typedef logic [7:0] byte_t;

endpackage

// ==== design/adc_result_trigger_regs.sv ====
/*
 * register side of a 10-bit converter: result bytes with alignment and
 * read lock, auto-trigger edge detection, pin input buffer gating, and an
 * AXI4-Lite slave with a sticky interrupt.
 * assumes: converter core, timer, comparator and interrupt flags run on
 * clk_i; analog pin levels are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`include "adc_trig_params.svh"

module adc_result_trigger_regs
   import adc_trig_pkg::*;
#(
   parameter int ADDR_W = 12,   // bus address width, at least 11
   parameter int PIN_N = 6      // pins with a digital buffer
) (
   input  wire logic clk_i,
   input  wire logic srst_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0] s_axi_wstrb_i,
   input  wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input  wire logic s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input  wire logic s_axi_rready_i,
   output logic conv_start_o,
   input  wire logic conv_done_i,
   input  wire logic [`RESULT_W-1:0] conv_result_i,
   output logic converter_enable_o,
   input  wire logic comparator_flag_i,
   input  wire logic ext_int0_flag_i,
   input  wire logic t0_compare_a_flag_i,
   input  wire logic t0_overflow_flag_i,
   input  wire logic t1_compare_b_flag_i,
   input  wire logic t1_overflow_flag_i,
   input  wire logic t1_capture_flag_i,
   input  wire logic [PIN_N-1:0] analog_pin_i,
   output logic [PIN_N-1:0] pin_buffer_disable_o,
   output logic [PIN_N-1:0] pin_digital_o,
   output logic comparator_mux_enable_o,
   output logic irq_o
);

   // bus state
   logic aw_full_q;             // write address held
   logic w_full_q;              // write data held
   byte_t aw_idx_q;             // held word index
   logic aw_bad_q;              // held address is unmapped
   byte_t w_data_q;             // held low data byte
   logic w_lane_q;              // low byte lane strobed
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   byte_t rdata_q;

   // block state
   byte_t ctrl_first_q;         // enable and auto bits only
   byte_t ctrl_second_q;        // comparator mux and source field
   byte_t chan_sel_q;           // alignment and channel bits
   byte_t pin_dis_q;            // buffer disable bits
   logic busy_q;                // conversion under way
   logic start_q;               // one-cycle start to the core
   logic done_flag_q;           // conversion done flag
   logic lock_q;                // low byte read, high not yet
   logic [`RESULT_W-1:0] result_q;
   logic [`IRQ_W-1:0] irq_status_q;
   logic [`IRQ_W-1:0] irq_mask_q;
   logic sel_prev_q;            // last sample of selected flag
   trig_src_e src_prev_q;       // last value of source field
   logic [PIN_N-1:0] pin_meta_q;
   logic [PIN_N-1:0] pin_sync_q;
   logic [PIN_N-1:0] pin_digital_q;

   // combinational helpers
   logic aw_hs, w_hs, ar_hs, wr_fire, wr_en;
   logic wr_ctrl1, wr_ctrl2, wr_chan, wr_pin, wr_stat, wr_mask;
   byte_t ar_idx;
   logic ar_bad;
   byte_t rd_byte;
   byte_t res_low, res_high;
   trig_src_e src;
   logic auto_on, enable_on, sel_flag, to_free, trig_edge;
   logic sw_start, trig_start, result_upd;

   // an index is mapped only if the bits above it are zero
   function automatic logic unmapped(input logic [ADDR_W-1:0] a);
      logic hit;
      byte_t i;
      i = a[`IDX_MSB:`IDX_LSB];
      hit = (i == `IDX_RES_LOW) || (i == `IDX_RES_HIGH) ||
            (i == `IDX_CTRL_FIRST) || (i == `IDX_CTRL_SECOND) ||
            (i == `IDX_CHAN_SEL) || (i == `IDX_PIN_DIS) ||
            (i == `IDX_IRQ_STATUS) || (i == `IDX_IRQ_MASK);
      if (a[ADDR_W-1:`IDX_MSB+1] != '0) begin
         hit = 1'b0;
      end
      return !hit;
   endfunction

   // channels accept only while nothing is pending on the response
   assign s_axi_awready_o = !aw_full_q && !bvalid_q;
   assign s_axi_wready_o = !w_full_q && !bvalid_q;
   assign s_axi_arready_o = !rvalid_q;
   assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
   assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
   assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
   assign wr_fire = aw_full_q && w_full_q;
   assign wr_en = wr_fire && w_lane_q && !aw_bad_q;
   assign wr_ctrl1 = wr_en && (aw_idx_q == `IDX_CTRL_FIRST);
   assign wr_ctrl2 = wr_en && (aw_idx_q == `IDX_CTRL_SECOND);
   assign wr_chan = wr_en && (aw_idx_q == `IDX_CHAN_SEL);
   assign wr_pin = wr_en && (aw_idx_q == `IDX_PIN_DIS);
   assign wr_stat = wr_en && (aw_idx_q == `IDX_IRQ_STATUS);
   assign wr_mask = wr_en && (aw_idx_q == `IDX_IRQ_MASK);
   assign ar_idx = s_axi_araddr_i[`IDX_MSB:`IDX_LSB];
   assign ar_bad = unmapped(s_axi_araddr_i);

   // write address and data are taken in either order, then fire together
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_idx_q <= `REG_RESET;
         aw_bad_q <= 1'b0;
         w_data_q <= `REG_RESET;
         w_lane_q <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_full_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr_i[`IDX_MSB:`IDX_LSB];
            aw_bad_q <= unmapped(s_axi_awaddr_i);
         end else if (wr_fire) begin
            aw_full_q <= 1'b0;
         end
         if (w_hs) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_i[7:0];
            w_lane_q <= s_axi_wstrb_i[0];
         end else if (wr_fire) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // write response; unmapped words answer decode error
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= aw_bad_q ? `RESP_DECERR : `RESP_OKAY;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;

   // result presentation follows the live alignment bit
   always_comb begin
      if (chan_sel_q[`CS_ALIGN]) begin
         res_high = result_q[9:2];
         res_low = {result_q[1:0], 6'h00};
      end else begin
         res_high = {6'h00, result_q[9:8]};
         res_low = result_q[7:0];
      end
   end

   // read mux; reserved bits are never stored, so they read zero
   always_comb begin
      rd_byte = `REG_RESET;
      if (ar_idx == `IDX_RES_LOW) begin
         rd_byte = res_low;
      end else if (ar_idx == `IDX_RES_HIGH) begin
         rd_byte = res_high;
      end else if (ar_idx == `IDX_CTRL_FIRST) begin
         rd_byte = ctrl_first_q;
         rd_byte[`CF_START] = busy_q || start_q;
         rd_byte[`CF_DONE] = done_flag_q;
      end else if (ar_idx == `IDX_CTRL_SECOND) begin
         rd_byte = ctrl_second_q;
      end else if (ar_idx == `IDX_CHAN_SEL) begin
         rd_byte = chan_sel_q;
      end else if (ar_idx == `IDX_PIN_DIS) begin
         rd_byte = pin_dis_q;
      end else if (ar_idx == `IDX_IRQ_STATUS) begin
         rd_byte = {6'h00, irq_status_q};
      end else if (ar_idx == `IDX_IRQ_MASK) begin
         rd_byte = {6'h00, irq_mask_q};
      end
      if (ar_bad) begin
         rd_byte = `REG_RESET;
      end
   end

   // read data is captured at the address handshake, one cycle to rvalid
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= `REG_RESET;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rresp_q <= ar_bad ? `RESP_DECERR : `RESP_OKAY;
         rdata_q <= rd_byte;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rresp_o = rresp_q;
   assign s_axi_rdata_o = {24'h00_0000, rdata_q};

   // software-written control; write masks keep reserved bits at zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_first_q <= `REG_RESET;
         ctrl_second_q <= `REG_RESET;
         chan_sel_q <= `REG_RESET;
         pin_dis_q <= `REG_RESET;
         irq_mask_q <= '0;
      end else begin
         if (wr_ctrl1) begin
            ctrl_first_q <= w_data_q & `CTRL_FIRST_WMASK;
         end
         if (wr_ctrl2) begin
            ctrl_second_q <= w_data_q & `CTRL_SECOND_WMASK;
         end
         if (wr_chan) begin
            chan_sel_q <= w_data_q & `CHAN_SEL_WMASK;
         end
         if (wr_pin) begin
            pin_dis_q <= w_data_q & `PIN_DIS_WMASK;
         end
         if (wr_mask) begin
            irq_mask_q <= w_data_q[`IRQ_W-1:0];
         end
      end
   end
   assign comparator_mux_enable_o = ctrl_second_q[`CB_COMP_MUX];
   assign converter_enable_o = ctrl_first_q[`CF_ENABLE];

   // trigger source decode
   assign src = trig_src_e'(ctrl_second_q[`TS_MSB:0]);
   always_comb begin
      case (src)
         TRIG_FREE_RUN: sel_flag = done_flag_q;
         TRIG_COMPARATOR: sel_flag = comparator_flag_i;
         TRIG_EXT_INT0: sel_flag = ext_int0_flag_i;
         TRIG_T0_CMP_A: sel_flag = t0_compare_a_flag_i;
         TRIG_T0_OVF: sel_flag = t0_overflow_flag_i;
         TRIG_T1_CMP_B: sel_flag = t1_compare_b_flag_i;
         TRIG_T1_OVF: sel_flag = t1_overflow_flag_i;
         default: sel_flag = t1_capture_flag_i;
      endcase
   end

   // edge detection on the muxed flag; a change of selection onto a set
   // flag also looks like a rising edge
   assign auto_on = ctrl_first_q[`CF_AUTO];
   assign enable_on = ctrl_first_q[`CF_ENABLE];
   assign to_free = (src == TRIG_FREE_RUN) && (src_prev_q != TRIG_FREE_RUN);
   assign trig_edge = sel_flag && !sel_prev_q && !to_free;
   assign trig_start = trig_edge && auto_on && enable_on;
   // a start written with the enable bit in the same write also counts
   assign sw_start = wr_ctrl1 && w_data_q[`CF_START] && w_data_q[`CF_ENABLE];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sel_prev_q <= 1'b0;
         src_prev_q <= TRIG_FREE_RUN;
      end else begin
         sel_prev_q <= sel_flag;
         src_prev_q <= src;
      end
   end

   // start pulse and busy; starts while busy are dropped, and clearing
   // the enable bit abandons a conversion under way
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         start_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         start_q <= (sw_start || trig_start) && !busy_q && !start_q;
         if (!enable_on) begin
            busy_q <= 1'b0;
         end else if (start_q) begin
            busy_q <= 1'b1;
         end else if (conv_done_i) begin
            busy_q <= 1'b0;
         end
      end
   end
   assign conv_start_o = start_q;

   // result capture is blocked between the low and high byte reads;
   // software relies on reading low first for a consistent pair
   assign result_upd = conv_done_i && !lock_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         result_q <= '0;
         lock_q <= 1'b0;
      end else begin
         if (result_upd) begin
            result_q <= conv_result_i;
         end
         if (ar_hs && !ar_bad && (ar_idx == `IDX_RES_LOW)) begin
            lock_q <= 1'b1;
         end else if (ar_hs && !ar_bad && (ar_idx == `IDX_RES_HIGH)) begin
            lock_q <= 1'b0;
         end
      end
   end

   // done flag: set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         done_flag_q <= 1'b0;
      end else if (result_upd) begin
         done_flag_q <= 1'b1;
      end else if (wr_ctrl1 && w_data_q[`CF_DONE]) begin
         done_flag_q <= 1'b0;
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_status_q <= '0;
      end else begin
         for (int b = 0; b < `IRQ_W; b++) begin
            if (wr_stat && w_data_q[b]) begin
               irq_status_q[b] <= 1'b0;
            end
         end
         if (result_upd) begin
            irq_status_q[`IRQ_DONE] <= 1'b1;
         end
         if (start_q) begin
            irq_status_q[`IRQ_TRIG] <= 1'b1;
         end
      end
   end
   assign irq_o = |(irq_status_q & irq_mask_q);

   // pins are asynchronous: two flops, then gate by the disable bits;
   // the disable bits and the gated pin levels leave the block, the analog path is outside
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
         pin_digital_q <= '0;
      end else begin
         pin_meta_q <= analog_pin_i;
         pin_sync_q <= pin_meta_q;
         pin_digital_q <= pin_sync_q & ~pin_dis_q[PIN_N-1:0];
      end
   end
   assign pin_buffer_disable_o = pin_dis_q[PIN_N-1:0];
   assign pin_digital_o = pin_digital_q;

   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   a_right_align_low: assert property (
      (ar_hs && !ar_bad && ar_idx == `IDX_RES_LOW && !chan_sel_q[`CS_ALIGN])
      |=> s_axi_rdata_o[7:0] == $past(result_q[7:0]))
      else $error("right aligned low byte wrong");
   a_left_align_high: assert property (
      (ar_hs && !ar_bad && ar_idx == `IDX_RES_HIGH && chan_sel_q[`CS_ALIGN])
      |=> s_axi_rdata_o[7:0] == $past(result_q[9:2]))
      else $error("left aligned high byte wrong");
   a_lock_holds: assert property (
      lock_q |=> result_q == $past(result_q))
      else $error("result changed while locked");
   a_auto_gate: assert property (
      (start_q && !$past(sw_start)) |-> $past(auto_on) && $past(enable_on))
      else $error("trigger start without auto enable");
   a_edge_start: assert property (
      (trig_start && !busy_q && !start_q) |=> conv_start_o ##1 !conv_start_o)
      else $error("edge did not give one start pulse");
   a_free_quiet: assert property (
      to_free |=> !start_q || $past(sw_start))
      else $error("switch to free running triggered");
   a_reserved_zero: assert property (
      (ctrl_second_q & ~`CTRL_SECOND_WMASK) == 8'h00 &&
      (pin_dis_q & ~`PIN_DIS_WMASK) == 8'h00)
      else $error("reserved bit set");
   a_pin_gate: assert property (
      (pin_digital_o & $past(pin_dis_q[PIN_N-1:0])) == '0)
      else $error("disabled pin reads one");
   a_done_set: assert property (
      result_upd |=> done_flag_q && result_q == $past(conv_result_i))
      else $error("done flag or result not updated");

   c_locked_pair: cover property (lock_q ##[1:20] !lock_q);
   c_auto_start: cover property (trig_start ##1 conv_start_o);
   c_left_read: cover property (ar_hs && chan_sel_q[`CS_ALIGN]);

endmodule

// ==== tb/tb_top.sv ====
/*
 * self-checking bench for the converter result and trigger register block.
 * assumes: the design and its package are compiled first; the bench acts
 * as bus master, converter core, trigger flag sources and pin drivers.
 */
`timescale 1ns/10ps
`include "adc_trig_params.svh"

module tb_top
   import adc_trig_pkg::*;
;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h1; // only the low byte lane carries data
   logic awready, wready, bvalid, arready, rvalid, irq_o, cmux, conv_start_o;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic conv_done_i = 1'b0;
   logic [9:0] conv_result_i = 10'h000;
   logic [7:1] flag = 7'h00; // trigger source flags, index is the code
   logic [5:0] pins = 6'h00, dis_o, dig_o;
   logic conv_en;
   logic [33:0] exp_q[$]; // expected {resp, data} of pending reads
   int mismatches = 0, cmp_count = 0, starts = 0, s0, seed = 32'h1ac9_8aa5;
   logic [1:0] rsp;
   logic [9:0] v1, v2;

   // 250 MHz system clock
   always #2 clk_i = ~clk_i;

   adc_result_trigger_regs adc_result_trigger_regs_i (
      .clk_i(clk_i), .srst_i(srst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .conv_start_o(conv_start_o),
      .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
      .converter_enable_o(conv_en), .comparator_flag_i(flag[1]),
      .ext_int0_flag_i(flag[2]), .t0_compare_a_flag_i(flag[3]),
      .t0_overflow_flag_i(flag[4]), .t1_compare_b_flag_i(flag[5]),
      .t1_overflow_flag_i(flag[6]), .t1_capture_flag_i(flag[7]),
      .analog_pin_i(pins), .pin_buffer_disable_o(dis_o),
      .pin_digital_o(dig_o), .comparator_mux_enable_o(cmux), .irq_o(irq_o)
   );

   // single comparison point; four-state compare so x matches only an expected x
   task automatic chk(input string nm, input logic [33:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // bus write; handshakes are judged in the second half of the cycle,
   // where every signal is settled, and acted on at the next rising edge
   task automatic wr(input byte_t idx, input byte_t d, output logic [1:0] r);
      int n;
      logic a, w, b;
      n = 0;
      b = 1'b0;
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b && n < 100) begin
         @(negedge clk_i);
         a = awvalid && awready;
         w = wvalid && wready;
         b = bready && bvalid;
         @(posedge clk_i);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
         r = bresp;
         n++;
      end
      chk("bvalid", 34'(b), 34'h1);
      @(posedge clk_i); // lets the released ready settle before reuse
   endtask

   task automatic wo(input byte_t idx, input byte_t d);
      wr(idx, d, rsp);
   endtask

   // bus read; the expectation is noted first, the monitor compares it
   task automatic rd(input byte_t idx, input byte_t e,
                     input logic [1:0] er = `RESP_OKAY);
      int n;
      logic a, r;
      n = 0;
      r = 1'b0;
      exp_q.push_back({er, 24'h00_0000, e});
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r && n < 100) begin
         @(negedge clk_i);
         a = arvalid && arready;
         r = rready && rvalid;
         @(posedge clk_i);
         if (a) arvalid <= 1'b0;
         if (r) rready <= 1'b0;
         n++;
      end
      @(posedge clk_i);
   endtask

   // converter core finishing a conversion with value v
   task automatic finish_conv(input logic [9:0] v);
      conv_result_i <= v;
      conv_done_i <= 1'b1;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // read monitor: pre-edge values, so no race with the design's updates
   always @(posedge clk_i) begin
      if (rvalid === 1'b1 && rready) begin
         if (exp_q.size() == 0) chk("read_extra", 34'h1, 34'h0);
         else chk("rdata", {rresp, rdata}, exp_q.pop_front());
      end
   end

   // counts start pulses handed to the converter core
   always @(posedge clk_i) begin
      if (conv_start_o === 1'b1) starts <= starts + 1;
   end

   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      cyc(20000);
      mismatches++;
      tally_and_finish();
   end

   initial begin
      v1 = 10'($random(seed));
      v2 = 10'($random(seed));
      cyc(12);
      srst_i <= 1'b0;
      cyc(1);
      rd(`IDX_RES_LOW, 8'h00);
      rd(`IDX_RES_HIGH, 8'h00);
      rd(`IDX_CTRL_SECOND, 8'h00);
      rd(`IDX_PIN_DIS, 8'h00);
      rd(8'h7D, 8'h00, `RESP_DECERR);
      wr(8'h7D, 8'h55, rsp);
      chk("bresp_unmapped", 34'(rsp), 34'(`RESP_DECERR));
      // software start, then result presentation and read lock
      wo(`IDX_CTRL_FIRST, 8'hC0);
      cyc(2);
      chk("start_sw", 34'(starts), 34'h1);
      chk("conv_on", 34'(conv_en), 34'h1);
      finish_conv(v1);
      rd(`IDX_RES_LOW, v1[7:0]);
      rd(`IDX_RES_HIGH, {6'h00, v1[9:8]});
      rd(`IDX_CTRL_FIRST, 8'h90);
      chk("irq_masked", 34'(irq_o), 34'h0);
      wo(`IDX_IRQ_MASK, 8'h01);
      chk("irq_on", 34'(irq_o), 34'h1);
      wo(`IDX_IRQ_STATUS, 8'h01);
      chk("irq_clr", 34'(irq_o), 34'h0);
      wo(`IDX_CTRL_FIRST, 8'h90); // clears the done flag, keeps enable
      rd(`IDX_CTRL_FIRST, 8'h80);
      rd(`IDX_RES_LOW, v1[7:0]);
      finish_conv(v2); // dropped while locked
      rd(`IDX_RES_HIGH, {6'h00, v1[9:8]});
      finish_conv(v2);
      rd(`IDX_RES_LOW, v2[7:0]);
      rd(`IDX_RES_HIGH, {6'h00, v2[9:8]});
      wo(`IDX_CHAN_SEL, 8'h20);
      rd(`IDX_RES_HIGH, v2[9:2]);
      rd(`IDX_RES_LOW, {v2[1:0], 6'h00});
      rd(`IDX_RES_HIGH, v2[9:2]);
      // source field has no effect without auto triggering
      wo(`IDX_CTRL_SECOND, 8'h01);
      s0 = starts;
      flag[1] <= 1'b1;
      cyc(4);
      chk("no_auto", 34'(starts - s0), 34'h0);
      flag[1] <= 1'b0;
      wo(`IDX_CTRL_FIRST, 8'hA0);
      // every source code except free running: one rising edge gives exactly one start
      for (int src = 1; src < 8; src++) begin
         wo(`IDX_CTRL_SECOND, 8'(src));
         cyc(2);
         s0 = starts;
         flag[src] <= 1'b1;
         cyc(4);
         chk("trig_src", 34'(starts - s0), 34'h1);
         flag[src] <= 1'b0;
         finish_conv(10'($random(seed)));
      end
      // moving the selection onto a flag that is already set
      flag[2] <= 1'b1;
      cyc(2);
      s0 = starts;
      wo(`IDX_CTRL_SECOND, 8'h02);
      cyc(2); // the pulse is counted on the same edge the write returns
      chk("sel_edge", 34'(starts - s0), 34'h1);
      finish_conv(10'h155); // leaves the done flag set
      // a low old flag makes the switch onto the set done flag look
      // like an edge, so only the free-running rule keeps it quiet
      flag[2] <= 1'b0;
      cyc(2);
      s0 = starts;
      wo(`IDX_CTRL_SECOND, 8'h00);
      cyc(4);
      chk("free_run", 34'(starts - s0), 34'h0);
      // free running: a completed conversion triggers the next one
      wo(`IDX_CTRL_FIRST, 8'hB0); // clears the done flag, keeps auto
      s0 = starts;
      finish_conv(10'h2AA);
      cyc(2);
      chk("free_trig", 34'(starts - s0), 34'h1);
      wo(`IDX_CTRL_FIRST, 8'h10);
      chk("conv_off", 34'(conv_en), 34'h0);
      wo(`IDX_CTRL_SECOND, 8'hFF);
      rd(`IDX_CTRL_SECOND, 8'h47);
      chk("comp_mux", 34'(cmux), 34'h1);
      // pin input buffers
      pins <= 6'($random(seed));
      cyc(5);
      chk("pins_on", 34'(dig_o), 34'(pins));
      wo(`IDX_PIN_DIS, 8'hFF);
      rd(`IDX_PIN_DIS, 8'h3F);
      chk("dis_out", 34'(dis_o), 34'h3F);
      cyc(4);
      chk("pins_off", 34'(dig_o), 34'h00);
      wo(`IDX_PIN_DIS, 8'h15);
      pins <= 6'h3F;
      cyc(5);
      chk("pins_mix", 34'(dig_o), 34'h2A);
      chk("reads_left", 34'(exp_q.size()), 34'h0);
      tally_and_finish();
   end
endmodule
